// >>> design/dbg_defines.svh
// Function
// - PROM answers when A15..A10 match its base; A9..A0 index words inside.
// - PROM data reaches the bus input lines only on address match with SMEMR.
// - card_match asserts when I/O address bits 7..3 equal the header value.
// - Controller chip enable needs card_match and A2 low; A1..A0 pick register.
// - Default bases are FC00 for the PROM and F0 for I/O.
// - Control register loads output data when BA0=0, BA1=1, write, card_match, A2 high.
// - Control bits 0..3 drive the four drive-select outputs.
// - Control bit 4 supplies head step pulses in place of the controller.
// - Control bit 5 is irq_gate and lets the board drive bus interrupts.
// - Control bit 6 is floppy_write_dir, the DMA transfer direction.
// - count_reg_select picks DMA address (0) or subsector count (1) register.
// - cnt_load_low/high write the low/high byte of the selected register.
// - Status read gates only input data bits 4 and 7 onto the bus.
// - dma_req_ff raises the DMA request toward the bus master.
// - Grant line accepted must match the request priority level used.
// - byte_done steps address and count; sequencing stops while it is high.
// - After grant the cycle-start flop drives PSYNC through grant gating.
// - DMA write strobes occur only while the subsector count is nonzero.
// - Chip enable selects controller and data ports and holds PRDY low unless ctrl_rd_en or ctrl_wr_en is on.
// - ctrl_rd_en starts a controller read, enables the input port on CPU reads only, asserts PRDY.
// - ctrl_wr_en puts controller data lines in write direction under chip select.
// - On grant out_port_rx_mode follows master_write_status and enables receivers.
// - Status bit 4 reads one while the subsector count is nonzero.
`ifndef DBG_DEFINES_SVH
`define DBG_DEFINES_SVH

`define DBG_IO_BASE 8'hf0
`define DBG_PROM_BASE 16'hfc00
`define DBG_OFS_CNT_LO 3'h4
`define DBG_OFS_CNT_HI 3'h5
`define DBG_OFS_CTL 3'h6
`define DBG_CTL_RESET 8'h00
`define DBG_CTL_STEP 4
`define DBG_CTL_IRQ 5
`define DBG_CTL_WRDIR 6
`define DBG_CTL_CNTSEL 7
`define DBG_STAT_NZ 4
`define DBG_STAT_BORROW 7
`define DBG_XFER_CYCLES 3
`define DBG_CTRL_DATA_REG 2'h3

`endif

// >>> design/dbg_pkg.sv
package dbg_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SYNC = 4'b0010,
    ST_XFER = 4'b0100,
    ST_END  = 4'b1000
  } dbg_state_e;
  typedef logic [15:0] dbg_word_t;
endpackage

// >>> design/dbg_bus_glue.sv
`timescale 1ns/1ps
`include "dbg_defines.svh"
module dbg_bus_glue import dbg_pkg::*; #(
  parameter logic [7:0] IO_BASE = `DBG_IO_BASE,
  parameter logic [15:0] PROM_BASE = `DBG_PROM_BASE,
  parameter int XFER_CYCLES = `DBG_XFER_CYCLES
) (
  input wire logic clk,                 // 250 MHz clock
  input wire logic rst_b,               // Board reset, active low
  input wire logic [15:0] addr,         // Bus address in
  input wire logic sMemR,               // Memory read status
  input wire logic sInp,                // I/O read status
  input wire logic sOut,                // I/O write status
  input wire logic pDbin,               // Read strobe
  input wire logic pWrIn_b,             // CPU write strobe, low active
  input wire logic [7:0] bufOutBits,    // Buffered output data
  output logic [7:0] inPortBits,        // Input data port
  output logic inPortEn,                // Input port drives bus
  output logic [9:0] promAddr,          // PROM word index
  input wire logic [7:0] promData,      // PROM word
  output logic promSel,                 // PROM selected
  output logic cardMatch,               // I/O base matched
  output logic ctrlCs_b,                // Controller chip select
  output logic [1:0] ctrlAddr,          // Controller register index
  output logic ctrlRdEn,                // Controller read enable
  output logic ctrlWrEn,                // Controller write enable
  input wire logic [7:0] dalIn,         // Controller data lines in
  output logic [7:0] dalOut,            // Controller data lines out
  output logic dalOe,                   // Controller data lines drive
  output logic pRdy,                    // Bus ready
  output logic [3:0] driveSel,          // Drive selects 0..3
  output logic stepRate,                // Step pulses from control bit 4
  output logic irqGate,                 // Interrupt enable
  input wire logic ctrlIrq,             // Controller interrupt
  output logic busIrq,                  // Gated bus interrupt
  output logic floppyWriteDir,          // 1 write to floppy
  output logic countRegSelect,          // 1 subsector count register
  input wire logic ctrlDataReq,         // Controller data request
  input wire logic dmaRcvd,             // No other DMA in progress
  output logic dmaReq,                  // DMA request line
  input wire logic dmaGrantIn,          // Matching DMA grant
  output logic pSync,                   // Bus cycle start
  output logic [15:0] dmaAddrOut,       // DMA memory address
  output logic dmaAddrOe,               // DMA address drive
  output logic pWrOut_b,                // DMA write strobe, low active
  output logic memRdStrobe,             // DMA memory read strobe
  input wire logic masterWriteStatus,   // Bus master write status
  output logic outPortRxEn,             // Output port receivers on
  output logic byteDone                 // Byte transferred
);

  function automatic logic portHit(input logic [2:0] low, input logic [2:0] ofs);
    portHit = (low == ofs);
  endfunction

  localparam int XC = XFER_CYCLES;

  logic [7:0] ctlReg;
  dbg_word_t dmaAddr;
  dbg_word_t subCount;
  logic subBorrow;
  logic dmaReqFf;
  logic outPortRxMode;
  logic [7:0] xferCnt;
  dbg_state_e state;
  dbg_state_e next_state;

  logic cpuWrite;
  logic cpuRead;
  logic chipEn;
  logic cardSelQualified;
  logic ctlLatchClk;
  logic ctlStatusGate;
  logic cntLoadLow;
  logic cntLoadHigh;
  logic cntLoad;
  logic subNonzero;
  logic dmaActive;
  logic cycleStartInt;
  logic writeStrobeInt;
  logic floppyReadFlag;

  // Address decode
  assign cpuWrite = sOut && !pWrIn_b;
  assign cpuRead = sInp && pDbin;
  assign cardMatch = (sInp || sOut) && (addr[7:3] == IO_BASE[7:3]);
  assign chipEn = cardMatch && !addr[2];
  assign cardSelQualified = cardMatch && addr[2];
  assign ctlLatchClk = cardSelQualified && cpuWrite && portHit(addr[2:0], `DBG_OFS_CTL);
  assign ctlStatusGate = cardSelQualified && cpuRead && portHit(addr[2:0], `DBG_OFS_CTL);
  assign cntLoadLow = cardSelQualified && cpuWrite && portHit(addr[2:0], `DBG_OFS_CNT_LO);
  assign cntLoadHigh = cardSelQualified && cpuWrite && portHit(addr[2:0], `DBG_OFS_CNT_HI);
  assign cntLoad = cntLoadLow || cntLoadHigh;
  assign promSel = sMemR && (addr[15:10] == PROM_BASE[15:10]);
  assign promAddr = addr[9:0];

  // Control register outputs
  assign driveSel = ctlReg[3:0];
  assign stepRate = ctlReg[`DBG_CTL_STEP];
  assign irqGate = ctlReg[`DBG_CTL_IRQ];
  assign busIrq = irqGate && ctrlIrq;
  assign floppyWriteDir = ctlReg[`DBG_CTL_WRDIR];
  assign countRegSelect = ctlReg[`DBG_CTL_CNTSEL];

  // DMA sequencing outputs
  assign subNonzero = (subCount != 16'h0000);
  assign dmaActive = (state == ST_SYNC) || (state == ST_XFER);
  assign cycleStartInt = (state == ST_SYNC);
  assign pSync = cycleStartInt && dmaGrantIn;
  assign byteDone = (state == ST_END);
  assign writeStrobeInt = (state == ST_XFER) && !floppyWriteDir && subNonzero;
  assign pWrOut_b = !writeStrobeInt;
  assign memRdStrobe = (state == ST_XFER) && floppyWriteDir;
  assign dmaReq = dmaReqFf;
  assign dmaAddrOut = dmaAddr;
  assign dmaAddrOe = dmaActive;
  assign outPortRxEn = outPortRxMode;
  assign floppyReadFlag = dmaActive && !floppyWriteDir;

  // Controller access
  assign ctrlRdEn = (chipEn && cpuRead) || floppyReadFlag;
  assign ctrlWrEn = (chipEn && cpuWrite) || (dmaActive && floppyWriteDir);
  assign ctrlCs_b = !(chipEn || dmaActive);
  assign ctrlAddr = dmaActive ? `DBG_CTRL_DATA_REG : addr[1:0];
  assign dalOut = bufOutBits;
  assign dalOe = ctrlWrEn && !ctrlCs_b;
  assign pRdy = !chipEn || ctrlRdEn || ctrlWrEn;

  // External control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctlReg <= `DBG_CTL_RESET;
    end else if (ctlLatchClk) begin
      ctlReg <= bufOutBits;
    end
  end

  // DMA address counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmaAddr <= 16'h0000;
    end else if (cntLoadLow && !countRegSelect) begin
      dmaAddr[7:0] <= bufOutBits;
    end else if (cntLoadHigh && !countRegSelect) begin
      dmaAddr[15:8] <= bufOutBits;
    end else if (byteDone) begin
      dmaAddr <= dmaAddr + 16'h0001;
    end
  end

  // Subsector counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      subCount <= 16'h0000;
    end else if (cntLoadLow && countRegSelect) begin
      subCount[7:0] <= bufOutBits;
    end else if (cntLoadHigh && countRegSelect) begin
      subCount[15:8] <= bufOutBits;
    end else if (byteDone) begin
      subCount <= subCount - 16'h0001;
    end
  end

  // Underflow flag, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      subBorrow <= 1'b0;
    end else if (byteDone && !subNonzero) begin
      subBorrow <= 1'b1;
    end else if (cntLoad && countRegSelect) begin
      subBorrow <= 1'b0;
    end
  end

  // DMA request flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmaReqFf <= 1'b0;
    end else if (byteDone) begin
      dmaReqFf <= 1'b0;
    end else if (state == ST_IDLE && ctrlDataReq && dmaRcvd) begin
      dmaReqFf <= 1'b1;
    end
  end

  // Receiver mode captured at grant
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outPortRxMode <= 1'b0;
    end else if (state == ST_IDLE && next_state == ST_SYNC) begin
      outPortRxMode <= masterWriteStatus;
    end else if (byteDone) begin
      outPortRxMode <= 1'b0;
    end
  end

  // Transfer length counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xferCnt <= 8'h00;
    end else if (state == ST_SYNC) begin
      xferCnt <= 8'(XC - 1);
    end else if (state == ST_XFER && xferCnt != 8'h00) begin
      xferCnt <= xferCnt - 8'h01;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (dmaReqFf && dmaGrantIn) begin
          next_state = ST_SYNC;
        end
      end
      ST_SYNC: next_state = ST_XFER;
      ST_XFER: begin
        if (xferCnt == 8'h00) begin
          next_state = ST_END;
        end
      end
      ST_END: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Input data port, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inPortBits <= 8'h00;
      inPortEn <= 1'b0;
    end else if (promSel) begin
      inPortBits <= promData;
      inPortEn <= 1'b1;
    end else if (ctlStatusGate) begin
      inPortBits <= 8'h00;
      inPortBits[`DBG_STAT_NZ] <= subNonzero;
      inPortBits[`DBG_STAT_BORROW] <= subBorrow;
      inPortEn <= 1'b1;
    end else if (chipEn && cpuRead) begin
      inPortBits <= dalIn;
      inPortEn <= 1'b1;
    end else begin
      inPortBits <= 8'h00;
      inPortEn <= 1'b0;
    end
  end

  a_ctl_load: assert property (@(posedge clk) disable iff (!rst_b)
    ctlLatchClk |=> ctlReg == $past(bufOutBits))
    else $error("Control register load wrong");

  a_drive_sel_map: assert property (@(posedge clk) disable iff (!rst_b)
    ctlLatchClk |=> driveSel == $past(bufOutBits[3:0]))
    else $error("Drive select mismatch");

  a_card_decode: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrlCs_b && !dmaActive |-> addr[7:3] == IO_BASE[7:3] && !addr[2])
    else $error("Chip select decode wrong");

  a_prom_drive: assert property (@(posedge clk) disable iff (!rst_b)
    inPortEn |-> $past(promSel) || $past(ctlStatusGate) || ($past(chipEn) && $past(cpuRead)))
    else $error("Input port driven without cause");

  a_status_bits: assert property (@(posedge clk) disable iff (!rst_b)
    $past(ctlStatusGate) && !$past(promSel) |-> inPortBits[6:5] == 2'b00 && inPortBits[3:0] == 4'h0
    && inPortBits[4] == ($past(subCount) != 16'h0000)) else $error("Status read bits wrong");

  a_psync_grant: assert property (@(posedge clk) disable iff (!rst_b)
    pSync |-> dmaGrantIn && $past(dmaReqFf) ##1 dmaActive [*2])
    else $error("PSYNC without grant");

  a_wr_strobe_nz: assert property (@(posedge clk) disable iff (!rst_b)
    !pWrOut_b |-> subCount != 16'h0000 && !floppyWriteDir)
    else $error("Write strobe at zero count");

  a_byte_step: assert property (@(posedge clk) disable iff (!rst_b)
    byteDone && !cntLoad |=> dmaAddr == $past(dmaAddr) + 16'h0001 && subCount == $past(subCount) - 16'h0001
    && !dmaReqFf && !dmaActive) else $error("Byte done step wrong");

  a_rx_mode: assert property (@(posedge clk) disable iff (!rst_b)
    cycleStartInt |-> outPortRxEn == $past(masterWriteStatus))
    else $error("Receiver mode not from status");

  a_latch_addr: assert property (@(posedge clk) disable iff (!rst_b)
    ctlLatchClk |-> addr[2:0] == 3'h6 && sOut && !pWrIn_b)
    else $error("Control latch on wrong access");

  a_prom_sel: assert property (@(posedge clk) disable iff (!rst_b)
    promSel |-> sMemR && addr[15:10] == PROM_BASE[15:10] && promAddr == addr[9:0])
    else $error("PROM select decode wrong");

  a_prom_data: assert property (@(posedge clk) disable iff (!rst_b)
    promSel |=> inPortEn && inPortBits == $past(promData))
    else $error("PROM word not on input port");

  a_card_match: assert property (@(posedge clk) disable iff (!rst_b)
    cardMatch |-> (sInp || sOut) && addr[7:3] == IO_BASE[7:3])
    else $error("Card match without address hit");

  a_step_dir_map: assert property (@(posedge clk) disable iff (!rst_b)
    ctlLatchClk |=> stepRate == $past(bufOutBits[4]) && floppyWriteDir == $past(bufOutBits[6]))
    else $error("Step or direction bit wrong");

  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !irqGate |-> !busIrq)
    else $error("Bus interrupt while gate closed");

  a_cnt_low_load: assert property (@(posedge clk) disable iff (!rst_b)
    cntLoadLow && countRegSelect |=> subCount[7:0] == $past(bufOutBits))
    else $error("Count low byte not loaded");

  a_cnt_high_load: assert property (@(posedge clk) disable iff (!rst_b)
    cntLoadHigh && !countRegSelect |=> dmaAddr[15:8] == $past(bufOutBits))
    else $error("Address high byte not loaded");

  a_req_cause: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(dmaReq) |-> $past(ctrlDataReq) && $past(dmaRcvd))
    else $error("DMA request without data request");

  a_grant_level: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(dmaAddrOe) |-> $past(dmaGrantIn) && $past(dmaReqFf))
    else $error("DMA cycle without matching grant");

  a_chip_ready: assert property (@(posedge clk) disable iff (!rst_b)
    chipEn && !cpuRead && !cpuWrite && !dmaActive |-> !pRdy && !ctrlCs_b)
    else $error("Ready while chip idle");

  a_read_enable: assert property (@(posedge clk) disable iff (!rst_b)
    chipEn && cpuRead |-> ctrlRdEn && pRdy && !ctrlCs_b)
    else $error("Controller read not enabled");

  a_write_dir: assert property (@(posedge clk) disable iff (!rst_b)
    chipEn && cpuWrite |-> ctrlWrEn && dalOe && dalOut == bufOutBits)
    else $error("Controller write not driven");

  a_reset_clear: assert property (@(posedge clk)
    !rst_b |=> ctlReg == `DBG_CTL_RESET && !dmaReqFf && state == ST_IDLE)
    else $error("Reset left state behind");

endmodule

// >>> tb/dbg_bus_master.sv
`timescale 1ns/1ps
module dbg_bus_master (
  input wire logic clk,              // Bus clock
  input wire logic rst_b,            // Reset, active low
  input wire logic dmaReq,           // Request from board
  input wire logic [1:0] grantDelay, // Cycles before grant
  input wire logic wrMode,           // Write status while granting
  output logic dmaGrantIn,           // Grant on the matching level
  output logic masterWriteStatus     // Master write status
);
  logic [1:0] waitCnt;
  always_ff @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dmaGrantIn <= 1'b0;
      waitCnt <= 2'h0;
    end else if (!dmaReq) begin
      dmaGrantIn <= 1'b0;
      waitCnt <= 2'h0;
    end else if (waitCnt >= grantDelay) begin
      dmaGrantIn <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
  // Released status line keeps changing
  always_ff @(negedge clk or negedge rst_b) begin
    if (!rst_b) masterWriteStatus <= 1'b0;
    else masterWriteStatus <= dmaReq ? wrMode : ~masterWriteStatus;
  end
endmodule

// >>> tb/dbg_bus_glue_tb.sv
`timescale 1ns/1ps
module dbg_bus_glue_tb import dbg_pkg::*;;
  localparam logic [7:0] IOB = 8'hf0;
  localparam logic [15:0] PB = 16'hfc00;
  logic clk, rst_b, sMemR, sInp, sOut, pDbin, pWrIn_b, ctrlIrq, ctrlDataReq, dmaRcvd, wrMode, hit;
  logic [15:0] addr, dmaAddrOut, a;
  logic [7:0] bufOutBits, promData, dalIn, inPortBits, dalOut, d;
  logic [9:0] promAddr;
  logic [3:0] driveSel;
  logic [1:0] ctrlAddr, grantDelay;
  logic inPortEn, promSel, cardMatch, ctrlCs_b, ctrlRdEn, ctrlWrEn, dalOe, pRdy, stepRate, irqGate, busIrq;
  logic floppyWriteDir, countRegSelect, dmaReq, dmaGrantIn, pSync, dmaAddrOe, pWrOut_b, memRdStrobe;
  logic masterWriteStatus, outPortRxEn, byteDone;
  logic [12:0] snap;
  logic [31:0] r;
  logic [31:0] seed = 32'h7999f43c;
  int mismatches = 0;
  int n_tests = 0;

  dbg_bus_glue #(.IO_BASE(IOB), .PROM_BASE(PB), .XFER_CYCLES(3)) uut (.clk, .rst_b, .addr, .sMemR, .sInp,
    .sOut, .pDbin, .pWrIn_b, .bufOutBits, .inPortBits, .inPortEn, .promAddr, .promData, .promSel, .cardMatch,
    .ctrlCs_b, .ctrlAddr, .ctrlRdEn, .ctrlWrEn, .dalIn, .dalOut, .dalOe, .pRdy, .driveSel, .stepRate, .irqGate,
    .ctrlIrq, .busIrq, .floppyWriteDir, .countRegSelect, .ctrlDataReq, .dmaRcvd, .dmaReq, .dmaGrantIn, .pSync,
    .dmaAddrOut, .dmaAddrOe, .pWrOut_b, .memRdStrobe, .masterWriteStatus, .outPortRxEn, .byteDone);
  dbg_bus_master master (.clk, .rst_b, .dmaReq, .grantDelay, .wrMode, .dmaGrantIn, .masterWriteStatus);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [7:0] stat(input logic nz, bw);
    return {bw, 2'h0, nz, 4'h0};
  endfunction
  function automatic logic [15:0] io(input logic [2:0] o);
    return {8'h00, IOB[7:3], o};
  endfunction
  task automatic chk(input logic [23:0] g, e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tend(input string s);
    $display("Test %s done", s);
  endtask
  // One bus cycle per clock, standing until the next call; snap keeps the controller-side view
  task automatic cyc(input logic [15:0] ad, input logic m, i, o, input logic [7:0] dt);
    addr = ad;
    sMemR = m;
    sInp = i;
    sOut = o;
    pDbin = m | i;
    pWrIn_b = ~o;
    bufOutBits = dt;
    #1 snap = {ctrlRdEn, ctrlWrEn, dalOe, pRdy, ctrlCs_b, dalOut};
    @(negedge clk);
  endtask
  task automatic rd(input logic [15:0] ad, input logic m, input logic [7:0] e);
    cyc(ad, m, ~m, 1'b0, 8'h00);
    chk({inPortEn, inPortBits}, {1'b1, e});
  endtask
  task automatic ctlchk(input logic [7:0] e);
    chk({countRegSelect, floppyWriteDir, irqGate, stepRate, driveSel}, e);
  endtask
  task automatic dma(input logic [15:0] ad, input logic w, input int ew, em);
    int nS = 0;
    int nW = 0;
    int nM = 0;
    int nB = 0;
    int nA = 0;
    {sMemR, sInp, sOut, pDbin} = 4'h0;
    pWrIn_b = 1'b1;
    wrMode = w;
    grantDelay = 2'(rnd());
    ctrlDataReq = 1'b1;
    @(negedge clk);
    ctrlDataReq = 1'b0;
    chk(dmaReq, 1'b1);
    for (int i = 0; i < 40 && nB == 0; i++) begin
      @(negedge clk);
      nS += pSync;
      nW += !pWrOut_b;
      nM += memRdStrobe;
      nB += byteDone;
      nA += dmaAddrOe;
      if (dmaAddrOe) chk({outPortRxEn, ctrlCs_b, ctrlAddr, dmaAddrOut}, {w, 3'h3, ad});
    end
    if (nB == 0) begin
      mismatches++;
      $display("MISMATCH t=%0t no byte done", $time);
      end_sim();
    end
    @(negedge clk);
    chk(nS, 1);
    chk(nW, ew);
    chk(nM, em);
    chk(nA, 4);
    chk({dmaReq, outPortRxEn, pSync}, 3'h0);
    tend("dma");
  endtask

  initial begin
    {sMemR, sInp, sOut, pDbin, ctrlIrq, ctrlDataReq, dmaRcvd, wrMode, rst_b} = 9'h000;
    pWrIn_b = 1'b1;
    addr = 16'h0000;
    {bufOutBits, promData, dalIn} = 24'h000000;
    grantDelay = 2'h0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chk({pWrOut_b, dmaReq, countRegSelect, floppyWriteDir, irqGate, stepRate, driveSel}, 10'h200);
    tend("reset");
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      d = r[7:0];
      ctrlIrq = r[8];
      dalIn = r[23:16];
      cyc(io(6), 1'b0, 1'b0, 1'b1, d);
      ctlchk(d);
      chk(busIrq, d[5] & r[8]);
      cyc({8'h00, ~IOB[7:3], 3'h6}, 1'b0, 1'b0, 1'b1, ~d);
      cyc(io(2), 1'b0, 1'b0, 1'b1, ~d);
      chk(snap, {5'b01110, ~d});
      rd(io(1), 1'b0, r[23:16]);
      chk(snap, {5'b10010, 8'h00});
      ctlchk(d);
    end
    tend("control");
    pDbin = 1'b0;
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      a = {r[31] ? PB[15:10] : r[15:10], r[9:8], r[30] ? IOB[7:3] : r[7:3], r[2:0]};
      addr = a;
      dalIn = r[27:20];
      {sMemR, sInp, sOut} = {r[17:16] == 2'h0, r[17:16] == 2'h1, r[17:16] == 2'h2};
      #1 hit = (sInp | sOut) && a[7:3] == IOB[7:3];
      chk(cardMatch, hit);
      chk({pRdy, ctrlCs_b}, {2{~(hit & ~a[2])}});
      if (hit & ~a[2]) chk(ctrlAddr, a[1:0]);
      chk({promSel, promAddr}, {sMemR && a[15:10] == PB[15:10], a[9:0]});
      @(negedge clk);
    end
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      promData = r[23:16];
      rd({PB[15:10], r[9:0]}, 1'b1, r[23:16]);
      cyc({~PB[15:10], r[9:0]}, 1'b1, 1'b0, 1'b0, 8'h00);
      chk(inPortEn, 1'b0);
    end
    tend("decode");
    cyc(io(6), 1'b0, 1'b0, 1'b1, 8'h80);
    cyc(io(4), 1'b0, 1'b0, 1'b1, 8'h01);
    cyc(io(5), 1'b0, 1'b0, 1'b1, 8'h00);
    rd(io(6), 1'b0, stat(1'b1, 1'b0));
    a = 16'(rnd());
    cyc(io(6), 1'b0, 1'b0, 1'b1, 8'h00);
    cyc(io(4), 1'b0, 1'b0, 1'b1, a[7:0]);
    cyc(io(5), 1'b0, 1'b0, 1'b1, a[15:8]);
    rd(io(6), 1'b0, stat(1'b1, 1'b0));
    ctrlDataReq = 1'b1;
    @(negedge clk);
    ctrlDataReq = 1'b0;
    chk(dmaReq, 1'b0);
    dmaRcvd = 1'b1;
    dma(a, 1'b1, 3, 0);
    rd(io(6), 1'b0, stat(1'b0, 1'b0));
    dma(a + 16'h1, 1'b0, 0, 0);
    rd(io(6), 1'b0, stat(1'b1, 1'b1));
    cyc(io(6), 1'b0, 1'b0, 1'b1, 8'h40);
    dma(a + 16'h2, 1'b1, 0, 3);
    cyc(io(6), 1'b0, 1'b0, 1'b1, 8'h80);
    cyc(io(4), 1'b0, 1'b0, 1'b1, 8'h05);
    rd(io(6), 1'b0, stat(1'b1, 1'b0));
    cyc(io(6), 1'b0, 1'b0, 1'b1, 8'hff);
    rst_b = 1'b0;
    #1 ctlchk(8'h00);
    @(negedge clk);
    rst_b = 1'b1;
    tend("counters");
    end_sim();
  end
endmodule
